/* hdl/ebr_bridge.sv */
module ebr_bridge (
	input wire logic clk, // 125 MHz bus clock
	input wire logic resetn, // async reset, active low
	input wire logic endian_select_pin, // sampled at reset release
	input wire logic req_valid, // internal access request
	input wire ebr_pkg::ebr_req_t req, // access descriptor
	input wire ebr_pkg::ebr_mem_t area_mem, // memory type of target area
	input wire logic [1:0] area_width, // bus width code of target area
	input wire logic [63:0] burst_wdata, // write data of current burst beat
	input wire logic ext_ack, // external cycle completes
	input wire logic [63:0] ext_rdata, // external read lanes
	input wire logic refresh_tick, // refresh counter count clock enable
	input wire ebr_pkg::ebr_reg_req_t reg_req, // refresh register access
	output ebr_pkg::ebr_bus_t ext_bus_ff, // external cycle address/data/lanes
	output logic ext_cyc_ff, // external cycle active
	output logic bus_lock_ff, // bus held, no release or refresh
	output logic req_ready_ff, // request accepted or refused
	output logic req_err_ff, // request refused
	output logic beat_done_ff, // one bus cycle finished
	output logic last_done_ff, // whole access finished
	output logic [63:0] rsp_data_ff, // read lanes of finished cycle
	output logic big_endian_ff, // latched endian mode
	output logic refresh_req_ff, // compare match pulse
	output logic [15:0] reg_rdata_ff // refresh register read data
);
	typedef enum {ST_IDLE, ST_CYCLE, ST_NEXT} ebr_state_t;

	function automatic logic width_ok(ebr_pkg::ebr_mem_t m, logic [1:0] w);
		case (m)
			ebr_pkg::MEM_NORMAL: width_ok = 1'b1;
			ebr_pkg::MEM_DRAM: width_ok = (w != ebr_pkg::BW_8);
			ebr_pkg::MEM_SDRAM: width_ok = (w == ebr_pkg::BW_32) || (w == ebr_pkg::BW_64);
			ebr_pkg::MEM_PCMCIA: width_ok = (w == ebr_pkg::BW_8) || (w == ebr_pkg::BW_16);
			default: width_ok = 1'b0;
		endcase
	endfunction

	function automatic logic [5:0] size_bytes(ebr_pkg::ebr_size_t s);
		case (s)
			ebr_pkg::SZ_BYTE: size_bytes = 6'h01;
			ebr_pkg::SZ_WORD: size_bytes = 6'h02;
			ebr_pkg::SZ_LONG: size_bytes = 6'h04;
			ebr_pkg::SZ_QUAD: size_bytes = 6'h08;
			default: size_bytes = ebr_pkg::BURST_BYTES;
		endcase
	endfunction

	ebr_state_t state_ff, nxt_state;
	logic por_seen_ff;
	logic [31:0] base_ff;
	logic [5:0] total_ff, done_ff;
	logic [3:0] wbytes_ff;
	logic burst_ff, write_ff;
	logic [63:0] wdata_ff;
	logic [7:0] ctrl_ff, counter_ff, constant_ff;
	logic [9:0] event_ff;

	// request acceptance and refusal
	wire [3:0] req_wbytes = 4'(4'h1 << area_width);
	wire req_width_ok = width_ok(area_mem, area_width);
	wire req_quad_bad = (req.size == ebr_pkg::SZ_QUAD) && !req.dma;
	wire req_bad = !req_width_ok || req_quad_bad;
	wire take = (state_ff == ST_IDLE) && req_valid && !req_ready_ff;

	// current beat geometry
	wire [5:0] remain = total_ff - done_ff;
	wire [5:0] chunk = (remain < {2'h0, wbytes_ff}) ? remain : {2'h0, wbytes_ff};
	wire [4:0] burst_ofs = 5'(base_ff[4:0] + done_ff[4:0]) & ebr_pkg::BURST_OFS_MASK;
	wire [31:0] beat_addr = burst_ff ? {base_ff[31:5], burst_ofs} : base_ff + {26'h0, done_ff};
	wire [3:0] in_word = 4'(beat_addr[2:0]) & 4'(wbytes_ff - 4'h1);
	wire [3:0] lane_lo = big_endian_ff ? 4'(wbytes_ff - in_word - 4'(chunk)) : in_word;
	wire [15:0] lane_ones = 16'(16'h1 << chunk) - 16'h1;
	wire [7:0] lane_mask = 8'(lane_ones << lane_lo);
	wire [5:0] src_byte = big_endian_ff ? 6'(total_ff - done_ff - chunk) : done_ff;
	wire [63:0] src_data = burst_ff ? burst_wdata : (wdata_ff >> {src_byte[2:0], 3'h0});
	wire [63:0] byte_keep = {lane_mask[7] ? 8'hFF : 8'h00, lane_mask[6] ? 8'hFF : 8'h00,
		lane_mask[5] ? 8'hFF : 8'h00, lane_mask[4] ? 8'hFF : 8'h00,
		lane_mask[3] ? 8'hFF : 8'h00, lane_mask[2] ? 8'hFF : 8'h00,
		lane_mask[1] ? 8'hFF : 8'h00, lane_mask[0] ? 8'hFF : 8'h00};
	wire [63:0] lane_data = burst_ff ? (src_data & byte_keep)
		: ((src_data << {lane_lo[2:0], 3'h0}) & byte_keep);
	wire beat_last = (done_ff + chunk) >= total_ff;
	// burst bus hold; a fresh request decides, a stale burst flag would hold the bus
	wire nxt_bus_lock = (take && !req_bad) ? (req.size == ebr_pkg::SZ_BURST32)
		: (burst_ff && (nxt_state != ST_IDLE));

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (take && !req_bad)
					nxt_state = ST_NEXT;
			end
			ST_NEXT: nxt_state = ST_CYCLE;
			ST_CYCLE: begin
				if (ext_ack)
					nxt_state = beat_last ? ST_IDLE : ST_NEXT;
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			por_seen_ff <= 1'b0;
			big_endian_ff <= 1'b1;
		end else if (!por_seen_ff) begin
			por_seen_ff <= 1'b1;
			big_endian_ff <= !endian_select_pin;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			base_ff <= 32'h0;
			total_ff <= 6'h0;
			wbytes_ff <= 4'h1;
			burst_ff <= 1'b0;
			write_ff <= 1'b0;
			wdata_ff <= 64'h0;
		end else if (take && !req_bad) begin
			base_ff <= req.addr;
			total_ff <= size_bytes(req.size);
			wbytes_ff <= req_wbytes;
			burst_ff <= (req.size == ebr_pkg::SZ_BURST32);
			write_ff <= req.write;
			wdata_ff <= req.wdata;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			done_ff <= 6'h0;
		end else if (take) begin
			done_ff <= 6'h0;
		end else if (state_ff == ST_CYCLE && ext_ack) begin
			done_ff <= 6'(done_ff + chunk);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ext_bus_ff <= '0;
			ext_cyc_ff <= 1'b0;
			bus_lock_ff <= 1'b0;
		end else begin
			if (state_ff == ST_NEXT) begin
				ext_bus_ff.addr <= beat_addr;
				ext_bus_ff.wdata <= write_ff ? lane_data : 64'h0;
				ext_bus_ff.lanes <= lane_mask;
				ext_bus_ff.write <= write_ff;
			end
			ext_cyc_ff <= (state_ff == ST_NEXT) || (state_ff == ST_CYCLE && !ext_ack);
			bus_lock_ff <= nxt_bus_lock;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			req_ready_ff <= 1'b0;
			req_err_ff <= 1'b0;
			beat_done_ff <= 1'b0;
			last_done_ff <= 1'b0;
			rsp_data_ff <= 64'h0;
		end else begin
			req_ready_ff <= take;
			req_err_ff <= take && req_bad;
			beat_done_ff <= (state_ff == ST_CYCLE) && ext_ack;
			last_done_ff <= (state_ff == ST_CYCLE) && ext_ack && beat_last;
			if (state_ff == ST_CYCLE && ext_ack)
				rsp_data_ff <= ext_rdata & byte_keep;
		end
	end

	wire key_byte_ok = reg_req.wdata[15:8] == ebr_pkg::KEY_BYTE;
	wire key_event_ok = reg_req.wdata[15:ebr_pkg::KEY_EVENT_LSB] == ebr_pkg::KEY_EVENT_COUNT;
	wire wr_ok = reg_req.wr && reg_req.word16;
	wire wr_ctrl = wr_ok && key_byte_ok && (reg_req.sel == ebr_pkg::SEL_CTRL_STATUS);
	wire wr_cnt = wr_ok && key_byte_ok && (reg_req.sel == ebr_pkg::SEL_COUNTER);
	wire wr_const = wr_ok && key_byte_ok && (reg_req.sel == ebr_pkg::SEL_CONSTANT);
	wire wr_event = wr_ok && key_event_ok && (reg_req.sel == ebr_pkg::SEL_EVENT_COUNT);
	wire match = (counter_ff == constant_ff) && refresh_tick && !bus_lock_ff;
	// set beats clear, writing 1 keeps
	wire nxt_match_flag = match || (ctrl_ff[ebr_pkg::MATCH_FLAG_BIT] &&
		!(wr_ctrl && !reg_req.wdata[ebr_pkg::MATCH_FLAG_BIT]));

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_ff <= ebr_pkg::RST_CTRL_STATUS;
			counter_ff <= ebr_pkg::RST_COUNTER;
			constant_ff <= ebr_pkg::RST_CONSTANT;
			event_ff <= ebr_pkg::RST_EVENT_COUNT;
			refresh_req_ff <= 1'b0;
		end else begin
			if (wr_ctrl)
				ctrl_ff <= {nxt_match_flag, reg_req.wdata[6:0]};
			else
				ctrl_ff[ebr_pkg::MATCH_FLAG_BIT] <= nxt_match_flag;
			if (match)
				counter_ff <= 8'h00;
			else if (wr_cnt)
				counter_ff <= reg_req.wdata[7:0];
			else if (refresh_tick && !bus_lock_ff)
				counter_ff <= 8'(counter_ff + 8'h01);
			if (wr_const)
				constant_ff <= reg_req.wdata[7:0];
			if (wr_event)
				event_ff <= reg_req.wdata[9:0];
			else if (match)
				event_ff <= 10'(event_ff + 10'h001);
			refresh_req_ff <= match;
		end
	end

	wire [15:0] rd_mux = (reg_req.sel == ebr_pkg::SEL_CTRL_STATUS) ? {8'h00, ctrl_ff}
		: (reg_req.sel == ebr_pkg::SEL_COUNTER) ? {8'h00, counter_ff}
		: (reg_req.sel == ebr_pkg::SEL_CONSTANT) ? {8'h00, constant_ff}
		: {6'h00, event_ff};

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata_ff <= 16'h0000;
		end else if (reg_req.rd) begin
			reg_rdata_ff <= rd_mux;
		end
	end
endmodule

/* hdl/ebr_pkg.sv */
package ebr_pkg;
	// access sizes seen on the internal side
	typedef enum logic [2:0] {
		SZ_BYTE,
		SZ_WORD,
		SZ_LONG,
		SZ_QUAD,
		SZ_BURST32
	} ebr_size_t;

	// memory type of the addressed area
	typedef enum logic [1:0] {
		MEM_NORMAL,
		MEM_DRAM,
		MEM_SDRAM,
		MEM_PCMCIA
	} ebr_mem_t;

	// bus width code: bytes = 1 << code
	localparam logic [1:0] BW_8 = 2'h0;
	localparam logic [1:0] BW_16 = 2'h1;
	localparam logic [1:0] BW_32 = 2'h2;
	localparam logic [1:0] BW_64 = 2'h3;

	localparam logic [5:0] BURST_BYTES = 6'h20;
	localparam logic [4:0] BURST_OFS_MASK = 5'h1F;

	// refresh register selectors
	localparam logic [1:0] SEL_CTRL_STATUS = 2'h0;
	localparam logic [1:0] SEL_COUNTER = 2'h1;
	localparam logic [1:0] SEL_CONSTANT = 2'h2;
	localparam logic [1:0] SEL_EVENT_COUNT = 2'h3;

	localparam logic [7:0] KEY_BYTE = 8'hA5;
	localparam logic [5:0] KEY_EVENT_COUNT = 6'h29;
	localparam int KEY_EVENT_LSB = 10;
	localparam int MATCH_FLAG_BIT = 7;

	localparam logic [7:0] RST_CTRL_STATUS = 8'h00;
	localparam logic [7:0] RST_COUNTER = 8'h00;
	localparam logic [7:0] RST_CONSTANT = 8'h00;
	localparam logic [9:0] RST_EVENT_COUNT = 10'h000;

	typedef struct packed {
		logic [31:0] addr;
		ebr_size_t size;
		logic write;
		logic dma;
		logic [63:0] wdata;
	} ebr_req_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [63:0] wdata;
		logic [7:0] lanes;
		logic write;
	} ebr_bus_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic word16;
		logic [1:0] sel;
		logic [15:0] wdata;
	} ebr_reg_req_t;
endpackage

/* test/ebr_mem_model.sv */
module ebr_mem_model (
	input wire logic clk, // bus clock
	input wire logic resetn, // async reset
	input wire logic cyc, // cycle active
	input wire logic [31:0] addr, // cycle address
	input wire logic [1:0] wait_cyc, // extra wait states
	output logic ack_ff, // cycle end
	output logic [63:0] rdata_ff // read lanes
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] cnt_ff;
	wire fire = cyc && !ack_ff && cnt_ff == wait_cyc;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_ff <= 2'h0;
			ack_ff <= 1'b0;
			rdata_ff <= 64'h0;
		end else begin
			ack_ff <= fire;
			// undriven lanes toggle so stale data never looks valid
			rdata_ff <= fire ? {2{addr}} : ~rdata_ff;
			cnt_ff <= (cyc && !ack_ff && !fire) ? cnt_ff + 2'h1 : 2'h0;
		end
	end
endmodule

/* test/ebr_checker.sv */
module ebr_checker (
	input wire logic clk, // bus clock
	input wire logic resetn, // async reset
	input wire logic endian_select_pin, // mode pin
	input wire logic req_valid, // request
	input wire ebr_pkg::ebr_req_t req, // descriptor
	input wire logic [1:0] area_width, // width code
	input wire logic ext_ack, // cycle end
	input wire logic refresh_tick, // count enable
	input wire ebr_pkg::ebr_bus_t ext_bus_ff, // bus fields
	input wire logic ext_cyc_ff, // cycle active
	input wire logic bus_lock_ff, // burst hold
	input wire logic req_ready_ff, // taken
	input wire logic req_err_ff, // refused
	input wire logic beat_done_ff, // beat end
	input wire logic last_done_ff, // access end
	input wire logic big_endian_ff, // mode
	input wire logic refresh_req_ff // match pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	sequence s_step;
		beat_done_ff && !last_done_ff;
	endsequence
	sequence s_take;
		req_ready_ff && req_valid;
	endsequence
	property p_err;
		req_err_ff |-> req_ready_ff;
	endproperty
	property p_last;
		last_done_ff |-> beat_done_ff;
	endproperty
	property p_ack;
		beat_done_ff |-> $past(ext_ack) && $past(ext_cyc_ff);
	endproperty
	property p_step;
		s_step ##0 !bus_lock_ff |=> ext_bus_ff.addr == $past(ext_bus_ff.addr) + (32'h1 << area_width);
	endproperty
	property p_wrap;
		s_step ##0 bus_lock_ff |=> ext_bus_ff.addr[31:5] == $past(ext_bus_ff.addr[31:5])
			&& ext_bus_ff.addr[4:0] == 5'($past(ext_bus_ff.addr[4:0]) + (5'h1 << area_width));
	endproperty
	property p_hold;
		bus_lock_ff && refresh_tick |=> !refresh_req_ff;
	endproperty
	property p_quad;
		s_take ##0 req.size == ebr_pkg::SZ_QUAD && !req.dma |-> req_err_ff;
	endproperty
	property p_mode;
		$rose(resetn) |=> big_endian_ff == !$past(endian_select_pin);
	endproperty
	property p_lane;
		s_take ##0 !req_err_ff && big_endian_ff && area_width == ebr_pkg::BW_64
			&& req.size == ebr_pkg::SZ_BYTE |=> ext_bus_ff.lanes == (8'h80 >> $past(req.addr[2:0]));
	endproperty
	a_err: assert property (p_err) else $error("refusal without ready");
	a_last: assert property (p_last) else $error("last without beat");
	a_ack: assert property (p_ack) else $error("beat without ack");
	a_step: assert property (p_step) else $error("bad address step");
	a_wrap: assert property (p_wrap) else $error("bad burst wrap");
	a_hold: assert property (p_hold) else $error("refresh inside burst");
	a_quad: assert property (p_quad) else $error("quad accepted");
	a_mode: assert property (p_mode) else $error("endian not latched");
	a_lane: assert property (p_lane) else $error("bad byte lane");
endmodule

/* test/tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; $display("unexpected at %0t: %h vs %h", $time, a, b); end end
	typedef struct {logic [11:0] a; int sz, dma, mem, w, err, beats; logic [7:0] ln;} ebr_row_t;
	logic clk = 0, resetn = 0, endian_select_pin = 0, req_valid = 0, refresh_tick = 0, ext_ack;
	ebr_pkg::ebr_req_t req = '0;
	ebr_pkg::ebr_mem_t area_mem = ebr_pkg::MEM_NORMAL;
	ebr_pkg::ebr_reg_req_t reg_req = '0;
	ebr_pkg::ebr_bus_t ext_bus_ff;
	logic [1:0] area_width = 2'h0, mem_wait = 2'h0;
	logic [63:0] burst_wdata = 64'h0, ext_rdata, rsp_data_ff;
	logic ext_cyc_ff, bus_lock_ff, req_ready_ff, req_err_ff, beat_done_ff, last_done_ff;
	logic big_endian_ff, refresh_req_ff;
	logic [15:0] reg_rdata_ff;
	int num_errors = 0, checks_done = 0, n_match = 0, cycles = 0;
	ebr_row_t rows[15] = '{'{12'h103,0,0,0,3,0,1,8'h10}, '{12'h107,0,0,0,3,0,1,8'h01},
		'{12'h102,1,0,0,3,0,1,8'h30}, '{12'h104,2,0,0,3,0,1,8'h0F}, '{12'h100,3,1,0,3,0,1,8'hFF},
		'{12'h108,3,0,0,3,1,0,8'h00}, '{12'h200,2,0,0,0,0,4,8'h00}, '{12'h204,2,0,1,0,1,0,8'h00},
		'{12'h208,2,0,2,1,1,0,8'h00}, '{12'h20C,2,0,3,2,1,0,8'h00}, '{12'h210,1,0,3,1,0,1,8'h00},
		'{12'h220,2,0,1,1,0,2,8'h00}, '{12'h318,4,0,2,3,0,4,8'h00}, '{12'h31D,4,0,0,0,0,32,8'h00},
		'{12'h314,4,1,2,2,0,8,8'h00}};
	ebr_bridge DUT (.*);
	ebr_mem_model mem (.clk, .resetn, .cyc(ext_cyc_ff), .addr(ext_bus_ff.addr),
		.wait_cyc(mem_wait), .ack_ff(ext_ack), .rdata_ff(ext_rdata));
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (refresh_req_ff === 1'b1) n_match++;
		// far above the few hundred cycles the tests need
		if (cycles == 20000) begin
			num_errors++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic do_reset(input logic p);
		resetn <= 1'b0;
		endian_select_pin <= p;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(posedge clk);
	endtask
	task automatic rw(input logic [1:0] s, input logic [15:0] d, input logic w16);
		@(posedge clk);
		reg_req <= '{1'b1, 1'b0, w16, s, d};
		@(posedge clk);
		reg_req <= '0;
	endtask
	task automatic rchk(input logic [1:0] s, input logic [15:0] e);
		@(posedge clk);
		reg_req <= '{1'b0, 1'b1, 1'b1, s, 16'h0};
		@(posedge clk);
		reg_req <= '0;
		@(posedge clk);
		`CHK(reg_rdata_ff, e)
	endtask
	function automatic logic [63:0] keep(input logic [7:0] m);
		for (int b = 0; b < 8; b++)
			keep[8 * b +: 8] = {8{m[b]}};
	endfunction
	task automatic acc(input ebr_row_t r, input logic wr = 1'b0, input logic [63:0] wd = 64'h0,
		input logic [63:0] ed = 64'h0);
		int k, n;
		logic [31:0] f, l, s;
		k = 0;
		n = 0;
		f = 0;
		l = 0;
		s = 32'((r.beats - 1) << r.w);
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{32'(r.a), ebr_pkg::ebr_size_t'(r.sz), wr, 1'(r.dma), wd};
		area_mem <= ebr_pkg::ebr_mem_t'(r.mem);
		area_width <= 2'(r.w);
		do begin
			@(posedge clk);
			k++;
		end while (req_ready_ff !== 1'b1 && k < 50);
		req_valid <= 1'b0;
		`CHK(req_err_ff, 1'(r.err))
		while (r.err == 0 && last_done_ff !== 1'b1 && k < 500) begin
			@(posedge clk);
			k++;
			// ticks offered during a burst must be held off
			refresh_tick <= bus_lock_ff && !last_done_ff;
			if (beat_done_ff === 1'b1) begin
				if (n == 0) f = ext_bus_ff.addr;
				if (n == 0 && r.ln != 8'h00) `CHK(ext_bus_ff.lanes, r.ln)
				if (n == 0 && r.ln != 8'h00) `CHK(rsp_data_ff, {2{32'(r.a)}} & keep(r.ln))
				if (n == 0) `CHK({ext_bus_ff.write, ext_bus_ff.wdata}, {wr, ed})
				l = ext_bus_ff.addr;
				n++;
			end
		end
		@(posedge clk);
		refresh_tick <= 1'b0;
		`CHK(n, r.beats)
		if (r.beats > 0) `CHK(f, 32'(r.a))
		if (r.beats > 0) `CHK(l, r.sz == 4 ? {20'h0, r.a[11:5], 5'(r.a[4:0] + s[4:0])} : 32'(r.a) + s)
	endtask
	task automatic tk();
		@(posedge clk);
		refresh_tick <= 1'b1;
		@(posedge clk);
		refresh_tick <= 1'b0;
	endtask
	initial begin
		do_reset(1'b0);
		`CHK(big_endian_ff, 1'b1)
		rw(2'h1, 16'hA537, 1'b1);
		rchk(2'h1, 16'h0037);
		rw(2'h1, 16'h5A12, 1'b1);
		rchk(2'h1, 16'h0037);
		rw(2'h1, 16'hA512, 1'b0);
		rchk(2'h1, 16'h0037);
		rw(2'h3, 16'hA555, 1'b1);
		rchk(2'h3, 16'h0155);
		rw(2'h2, 16'hA503, 1'b1);
		rw(2'h1, 16'hA500, 1'b1);
		repeat (4) tk();
		rchk(2'h1, 16'h0000);
		`CHK(n_match, 1)
		rchk(2'h0, 16'h0080);
		rw(2'h0, 16'hA500, 1'b1);
		rchk(2'h0, 16'h0000);
		rchk(2'h3, 16'h0156);
		$display("test registers done");
		foreach (rows[i]) begin
			mem_wait <= 2'(i);
			acc(rows[i]);
		end
		$display("test accesses done");
		acc(rows[3], 1'b1, 64'h11223344, 64'h11223344);
		acc(rows[2], 1'b1, 64'hAABB, 64'h0000AABB00000000);
		acc(rows[6], 1'b1, 64'h11223344, 64'h11);
		burst_wdata <= 64'h0123456789ABCDEF;
		acc(rows[12], 1'b1, 64'h0, 64'h0123456789ABCDEF);
		$display("test writes done");
		do_reset(1'b1);
		`CHK(big_endian_ff, 1'b0)
		acc(rows[6]);
		acc(rows[6], 1'b1, 64'h11223344, 64'h44);
		acc('{12'h103, 0, 0, 0, 3, 0, 1, 8'h08});
		$display("test little endian done");
		summarize();
	end
endmodule
bind ebr_bridge ebr_checker u_chk (.*);
